//--- common/cct_pkg.sv
// shared constants for the second converter control register block
package cct_pkg;
	// clock
	localparam int CLK_MHZ = 250;

	// register map and field layout
	localparam logic [7:0] CTRL_TWO_OFS   = 8'h02;
	localparam int         PGD_LSB        = 6;
	localparam int         FREQ_LSB       = 4;
	localparam int         SSTOP_BIT      = 3;
	localparam int         ILIM_LSB       = 0;
	localparam logic [1:0] PGD_RESET      = 2'h3;
	localparam logic [1:0] FREQ_RESET     = 2'h0;
	localparam logic       SSTOP_RESET    = 1'b0;
	localparam logic [2:0] ILIM_RESET     = 3'h1;
	localparam logic [7:0] CTRL_TWO_RESET = {PGD_RESET, FREQ_RESET, SSTOP_RESET, ILIM_RESET};
	localparam logic [7:0] UNMAPPED_DATA  = 8'h00;

	// power-good filter delays in ns and derived cycle counts (least times, rounded up)
	localparam int PGD0_NS  = 900;
	localparam int PGD1_NS  = 6000;
	localparam int PGD2_NS  = 12000;
	localparam int PGD3_NS  = 30000;
	localparam int PGD0_CYC = (PGD0_NS * CLK_MHZ + 999) / 1000;
	localparam int PGD1_CYC = (PGD1_NS * CLK_MHZ + 999) / 1000;
	localparam int PGD2_CYC = (PGD2_NS * CLK_MHZ + 999) / 1000;
	localparam int PGD3_CYC = (PGD3_NS * CLK_MHZ + 999) / 1000;
	localparam int PGD_CNT_W = 13;

	// serial slave states
	typedef enum logic [6:0] {
		ST_IDLE = 7'b0000001,
		ST_ADDR = 7'b0000010,
		ST_AACK = 7'b0000100,
		ST_WR   = 7'b0001000,
		ST_WACK = 7'b0010000,
		ST_RD   = 7'b0100000,
		ST_RACK = 7'b1000000
	} cct_state_e;
endpackage

//--- rtl/cct_pg_filter.sv
// power-good deglitch filter with selectable delay
`timescale 1ns/10ps
`default_nettype none
module cct_pg_filter #(
	parameter int CNT_W  = cct_pkg::PGD_CNT_W,
	parameter int DLY0   = cct_pkg::PGD0_CYC,
	parameter int DLY1   = cct_pkg::PGD1_CYC,
	parameter int DLY2   = cct_pkg::PGD2_CYC,
	parameter int DLY3   = cct_pkg::PGD3_CYC
) (
	// clock and reset
	input  wire logic       clk,
	input  wire logic       rst_n,
	// control and status
	input  wire logic [1:0] delay_sel,
	input  wire logic       in_window,
	output logic            power_good_flag
);
	import cct_pkg::*;

	// elaboration check: every delay must be at least one cycle, and DLY3 alone is checked to fit the counter
	if (DLY0 < 1 || DLY1 < 1 || DLY2 < 1 || DLY3 < 1 || DLY3 >= (1 << CNT_W)) begin : g_bad_delay
		$error("cct_pg_filter: delay counts out of range");
	end

	logic [CNT_W-1:0] cnt_reg;
	logic [CNT_W-1:0] cnt_next;
	logic             flag_reg;
	logic             flag_next;
	logic [CNT_W-1:0] lim;

	//////////////////////////////////////////////////////////////////////////
	// delay select decode
	always_comb begin
		case (delay_sel)
			2'h0:    lim = CNT_W'(DLY0);
			2'h1:    lim = CNT_W'(DLY1);
			2'h2:    lim = CNT_W'(DLY2);
			default: lim = CNT_W'(DLY3);
		endcase
	end

	// flag moves only after a full delay of disagreement, either direction
	always_comb begin
		cnt_next  = '0;
		flag_next = flag_reg;
		if (in_window != flag_reg) begin
			if (cnt_reg >= lim - CNT_W'(1)) begin
				flag_next = in_window;
			end else begin
				cnt_next = cnt_reg + CNT_W'(1);
			end
		end
	end

	// a glitch shorter than the delay restarts the count, so it never reaches the pin
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_reg  <= '0;
			flag_reg <= 1'b0;
		end else begin
			cnt_reg  <= cnt_next;
			flag_reg <= flag_next;
		end
	end

	assign power_good_flag = flag_reg;

	//////////////////////////////////////////////////////////////////////////
	chk_pg_change_after_delay: assert property (@(posedge clk) disable iff (!rst_n)
		$changed(flag_reg) |-> ($past(cnt_reg) >= $past(lim) - CNT_W'(1)) && $past(in_window != flag_reg))
		else $error("power good changed before its delay ran out");

	chk_pg_hold_when_agree: assert property (@(posedge clk) disable iff (!rst_n)
		(in_window == flag_reg) |=> $stable(flag_reg) && (cnt_reg == '0))
		else $error("power good moved while input agreed");

	chk_pg_delay_select: assert property (@(posedge clk) disable iff (!rst_n)
		(delay_sel == 2'h3) |-> (lim == CNT_W'(DLY3)))
		else $error("longest delay code does not select longest delay");
endmodule
`default_nettype wire

//--- rtl/cct_ctrl_two.sv
// second converter control register with serial slave and power-good filter
`timescale 1ns/10ps
`default_nettype none
module cct_ctrl_two #(
	parameter logic [6:0] DEV_ADDR  = 7'h20,
	parameter int         PGD3_CYCLES = cct_pkg::PGD3_CYC
) (
	// clock and reset
	input  wire logic       clk,
	input  wire logic       rst_n,
	// serial bus pins, data is open drain
	input  wire logic       scl_i,
	input  wire logic       sda_i,
	output logic            sda_o,
	output logic            sda_oe,
	// converter status pins
	input  wire logic       fb_in_window,
	input  wire logic       converter_enable,
	// decoded settings to the power stage
	output logic [1:0]      freq_sel,
	output logic [2:0]      valley_limit_sel,
	output logic            soft_stop_active,
	// open-drain power good pin
	output logic            power_good_flag,
	output logic            pg_o,
	output logic            pg_oe
);
	import cct_pkg::*;

	// read data for a pointer, used at address ack and each read reload
	function automatic logic [7:0] read_data(input logic [7:0] p, input logic [7:0] r);
		read_data = (p == CTRL_TWO_OFS) ? r : UNMAPPED_DATA;
	endfunction

	//////////////////////////////////////////////////////////////////////////
	// pin synchronisers; third stage only feeds edge detection
	logic [2:0] scl_sh;
	logic [2:0] sda_sh;
	logic [1:0] fb_sh;
	logic [1:0] en_sh;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			scl_sh <= 3'h7;
			sda_sh <= 3'h7;
			fb_sh  <= 2'h0;
			en_sh  <= 2'h0;
		end else begin
			scl_sh <= {scl_sh[1:0], scl_i};
			sda_sh <= {sda_sh[1:0], sda_i};
			fb_sh  <= {fb_sh[0], fb_in_window};
			en_sh  <= {en_sh[0], converter_enable};
		end
	end

	logic scl_rise;
	logic scl_fall;
	logic bus_start;
	logic bus_stop;
	logic sda_s;
	assign sda_s     = sda_sh[1];
	assign scl_rise  = scl_sh[1] & ~scl_sh[2];
	assign scl_fall  = ~scl_sh[1] & scl_sh[2];
	assign bus_start = scl_sh[1] & scl_sh[2] & sda_sh[2] & ~sda_sh[1];
	assign bus_stop  = scl_sh[1] & scl_sh[2] & ~sda_sh[2] & sda_sh[1];

	//////////////////////////////////////////////////////////////////////////
	// serial slave and register state
	cct_state_e state_reg, state_next;
	logic [3:0] bit_reg, bit_next;
	logic [7:0] shift_reg, shift_next;
	logic [7:0] ptr_reg, ptr_next;
	logic [7:0] ctrl_reg, ctrl_next;
	logic       rw_reg, rw_next;
	logic       have_ptr_reg, have_ptr_next;
	logic       oe_reg, oe_next;
	logic       written_reg, written_next;

	// readback word for the current pointer, shared by first load and reloads
	logic [7:0] rd_word;
	assign rd_word = read_data(ptr_reg, ctrl_reg);

	// next-state: sample on scl rise, drive on scl fall; start and stop override all
	always_comb begin
		state_next    = state_reg;
		bit_next      = bit_reg;
		shift_next    = shift_reg;
		ptr_next      = ptr_reg;
		ctrl_next     = ctrl_reg;
		rw_next       = rw_reg;
		have_ptr_next = have_ptr_reg;
		oe_next       = oe_reg;
		written_next  = written_reg;
		if (bus_start) begin
			state_next    = ST_ADDR;
			bit_next      = 4'h0;
			have_ptr_next = 1'b0;
			oe_next       = 1'b0;
		end else if (bus_stop) begin
			state_next = ST_IDLE;
			oe_next    = 1'b0;
		end else if (scl_rise) begin
			case (state_reg)
				ST_ADDR, ST_WR: begin
					shift_next = {shift_reg[6:0], sda_s};
					bit_next   = bit_reg + 4'h1;
				end
				ST_RD: bit_next = bit_reg + 4'h1;
				ST_RACK: begin
					if (sda_s) state_next = ST_IDLE; // not acknowledged: stop sending
				end
				default: ;
			endcase
		end else if (scl_fall) begin
			case (state_reg)
				ST_ADDR: begin
					if (bit_reg == 4'h8) begin
						if (shift_reg[7:1] == DEV_ADDR) begin
							state_next = ST_AACK;
							rw_next    = shift_reg[0];
							oe_next    = 1'b1;
						end else begin
							state_next = ST_IDLE;
						end
					end
				end
				ST_AACK: begin
					bit_next = 4'h0;
					if (rw_reg) begin
						shift_next = rd_word;
						oe_next    = ~rd_word[7];
						state_next = ST_RD;
					end else begin
						oe_next    = 1'b0;
						state_next = ST_WR;
					end
				end
				ST_WR: begin
					if (bit_reg == 4'h8) begin
						oe_next    = 1'b1;
						state_next = ST_WACK;
						if (!have_ptr_reg) begin
							ptr_next      = shift_reg;
							have_ptr_next = 1'b1;
						end else if (ptr_reg == CTRL_TWO_OFS) begin
							ctrl_next    = shift_reg;
							written_next = 1'b1;
						end
					end
				end
				ST_WACK: begin
					oe_next    = 1'b0;
					bit_next   = 4'h0;
					state_next = ST_WR;
				end
				ST_RD: begin
					if (bit_reg == 4'h8) begin
						oe_next    = 1'b0;
						state_next = ST_RACK;
					end else begin
						shift_next = {shift_reg[6:0], 1'b0};
						oe_next    = ~shift_reg[6];
					end
				end
				ST_RACK: begin
					// repeated reads return the same register
					shift_next = rd_word;
					oe_next    = ~rd_word[7];
					bit_next   = 4'h0;
					state_next = ST_RD;
				end
				default: state_next = ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg    <= ST_IDLE;
			bit_reg      <= 4'h0;
			shift_reg    <= 8'h00;
			ptr_reg      <= 8'h00;
			ctrl_reg     <= CTRL_TWO_RESET;
			rw_reg       <= 1'b0;
			have_ptr_reg <= 1'b0;
			oe_reg       <= 1'b0;
			written_reg  <= 1'b0;
		end else begin
			state_reg    <= state_next;
			bit_reg      <= bit_next;
			shift_reg    <= shift_next;
			ptr_reg      <= ptr_next;
			ctrl_reg     <= ctrl_next;
			rw_reg       <= rw_next;
			have_ptr_reg <= have_ptr_next;
			oe_reg       <= oe_next;
			written_reg  <= written_next;
		end
	end

	assign sda_o  = 1'b0;
	assign sda_oe = oe_reg;

	//////////////////////////////////////////////////////////////////////////
	// registered settings; highest frequency code passed as written, the host owns on-time limits
	logic [1:0] freq_reg, freq_next;
	logic [2:0] ilim_reg, ilim_next;
	logic       sstop_reg, sstop_next;
	always_comb begin
		freq_next  = ctrl_reg[FREQ_LSB +: 2];
		ilim_next  = ctrl_reg[ILIM_LSB +: 3];
		// ramp down only while shut down and soft stop chosen
		sstop_next = ctrl_reg[SSTOP_BIT] & ~en_sh[1];
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			freq_reg  <= FREQ_RESET;
			ilim_reg  <= ILIM_RESET;
			sstop_reg <= 1'b0;
		end else begin
			freq_reg  <= freq_next;
			ilim_reg  <= ilim_next;
			sstop_reg <= sstop_next;
		end
	end

	assign freq_sel         = freq_reg;
	assign valley_limit_sel = ilim_reg;
	assign soft_stop_active = sstop_reg;

	//////////////////////////////////////////////////////////////////////////
	// deglitch filter on the synchronised window comparator
	cct_pg_filter #(
		.CNT_W (PGD_CNT_W),
		.DLY0  (PGD0_CYC),
		.DLY1  (PGD1_CYC),
		.DLY2  (PGD2_CYC),
		.DLY3  (PGD3_CYCLES)
	) u_pg_filter (
		.clk             (clk),
		.rst_n           (rst_n),
		.delay_sel       (ctrl_reg[PGD_LSB +: 2]),
		.in_window       (fb_sh[1]),
		.power_good_flag (power_good_flag)
	);

	// pin pulled low whenever power is not good
	assign pg_o  = 1'b0;
	assign pg_oe = ~power_good_flag;

	//////////////////////////////////////////////////////////////////////////
	chk_reset_defaults: assert property (@(posedge clk) disable iff (!rst_n)
		!written_reg |-> (ctrl_reg == CTRL_TWO_RESET))
		else $error("register left its defaults without a write");

	chk_write_stores: assert property (@(posedge clk) disable iff (!rst_n)
		(scl_fall && !bus_start && !bus_stop && state_reg == ST_WR && bit_reg == 4'h8
			&& have_ptr_reg && ptr_reg == CTRL_TWO_OFS) |=> (ctrl_reg == $past(shift_reg)))
		else $error("write data not stored");

	chk_read_load: assert property (@(posedge clk) disable iff (!rst_n)
		(state_reg == ST_AACK && state_next == ST_RD && ptr_reg == CTRL_TWO_OFS)
			|=> (shift_reg == $past(ctrl_reg)) && (sda_oe == ~$past(ctrl_reg[7])))
		else $error("readback does not present stored value");

	chk_freq_follow: assert property (@(posedge clk) disable iff (!rst_n)
		$changed(ctrl_reg[FREQ_LSB +: 2]) |=> ##[0:1] (freq_sel == ctrl_reg[FREQ_LSB +: 2]))
		else $error("frequency select did not follow register");

	chk_ilim_follow: assert property (@(posedge clk) disable iff (!rst_n)
		##1 (valley_limit_sel == $past(ctrl_reg[ILIM_LSB +: 3])))
		else $error("current limit select did not follow register");

	chk_soft_stop: assert property (@(posedge clk) disable iff (!rst_n)
		soft_stop_active |-> $past(ctrl_reg[SSTOP_BIT]) && !$past(en_sh[1]))
		else $error("soft stop active without setting and shutdown");
endmodule
`default_nettype wire

//--- test/cct_i2c_host.sv
// serial bus host model that drives the clock and open-drain data line
`timescale 1ns/10ps
`default_nettype none
module cct_i2c_host (
	// clock
	input  wire logic clk,
	// bus pins, data line has a pull-up
	input  wire logic sda_line,
	output logic      scl,
	output logic      sda_pull
);
	initial begin
		scl = 1'b1;
		sda_pull = 1'b0;
	end
	// a third of a bit, 8 clocks, twice the shortest phase the slave takes
	task automatic phase();
		repeat (8) @(negedge clk);
	endtask
	// data falls while the clock is high; also serves as repeated start
	task automatic start();
		sda_pull = 1'b0;
		phase();
		scl = 1'b1;
		phase();
		sda_pull = 1'b1;
		phase();
		scl = 1'b0;
		phase();
	endtask
	task automatic stop();
		sda_pull = 1'b1;
		phase();
		scl = 1'b1;
		phase();
		sda_pull = 1'b0;
		phase();
	endtask
	// data moves only a full phase after the clock fell, never near its edges
	task automatic bit_io(input logic b, output logic r);
		sda_pull = ~b;
		phase();
		scl = 1'b1;
		phase();
		r = sda_line;
		scl = 1'b0;
		phase();
	endtask
	task automatic byte_out(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], r);
		end
		bit_io(1'b1, r);
		ack = ~r;
	endtask
	task automatic byte_in(input logic last, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, r);
			d[i] = r;
		end
		bit_io(last, r);
	endtask
	// host picks frequency codes
	// the top code is sent only on the assumption that on-time allows it
	task automatic write_reg(input logic [6:0] addr, input logic [7:0] ptr, input logic [7:0] d, output logic ok);
		logic a0, a1, a2;
		start();
		byte_out({addr, 1'b0}, a0);
		byte_out(ptr, a1);
		byte_out(d, a2);
		stop();
		ok = a0 & a1 & a2;
	endtask
	task automatic read_reg(input logic [6:0] addr, input logic [7:0] ptr, output logic [7:0] d, output logic ok);
		logic a0, a1, a2;
		start();
		byte_out({addr, 1'b0}, a0);
		byte_out(ptr, a1);
		start();
		byte_out({addr, 1'b1}, a2);
		byte_in(1'b1, d);
		stop();
		ok = a0 & a1 & a2;
	endtask
endmodule
`default_nettype wire

//--- test/test_cct_ctrl_two.sv
// self-checking bench for the second converter control register
`timescale 1ns/10ps
`default_nettype none
module test_cct_ctrl_two;
	import cct_pkg::*;
	localparam int         PGD3_SMALL = 40;
	localparam logic [6:0] ADDR       = 7'h20;
	logic       clk, rst_n, fb_in_window, converter_enable, scl, sda_pull, sda_o, sda_oe;
	logic       soft_stop_active, power_good_flag, pg_o, pg_oe, ok;
	logic [1:0] freq_sel;
	logic [2:0] valley_limit_sel;
	logic [7:0] rd_data;
	int         n_mismatch, tests_run;
	int         dly [4];
	wire logic  sda_line;
	// open-drain data wire: low while either side pulls
	assign sda_line = (sda_pull | sda_oe) ? 1'b0 : 1'b1;
	cct_ctrl_two #(.DEV_ADDR(ADDR), .PGD3_CYCLES(PGD3_SMALL)) i_cct_ctrl_two (.clk(clk), .rst_n(rst_n),
		.scl_i(scl), .sda_i(sda_line), .sda_o(sda_o), .sda_oe(sda_oe), .fb_in_window(fb_in_window),
		.converter_enable(converter_enable), .freq_sel(freq_sel), .valley_limit_sel(valley_limit_sel),
		.soft_stop_active(soft_stop_active), .power_good_flag(power_good_flag), .pg_o(pg_o), .pg_oe(pg_oe));
	cct_i2c_host i_cct_i2c_host (.clk(clk), .sda_line(sda_line), .scl(scl), .sda_pull(sda_pull));
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wrap_up();
		$display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
		if (n_mismatch == 0 && tests_run > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic rd(input logic [7:0] ptr, input logic [7:0] exp);
		i_cct_i2c_host.read_reg(ADDR, ptr, rd_data, ok);
		check("read ack", 8'(ok), 8'h01);
		check("read data", rd_data, exp);
	endtask
	task automatic wr(input logic [7:0] d);
		i_cct_i2c_host.write_reg(ADDR, CTRL_TWO_OFS, d, ok);
		check("write ack", 8'(ok), 8'h01);
	endtask
	// bounded wait for the flag; delay must land just past the selected count
	task automatic wait_pg(input logic exp, input int n_min);
		int n;
		n = 0;
		while (power_good_flag !== exp) begin
			@(negedge clk);
			n++;
			if (n > n_min + 20) begin
				n_mismatch++;
				wrap_up();
			end
		end
		check("pg delay in range", 8'(n >= n_min && n <= n_min + 4), 8'h01);
		check("pg pin", 8'(pg_oe), 8'(!exp));
	endtask
	task automatic t_reset();
		check("freq", 8'(freq_sel), 8'h00);
		check("limit", 8'(valley_limit_sel), 8'h01);
		check("soft stop", 8'(soft_stop_active), 8'h00);
		check("pg pin", 8'(pg_oe), 8'h01);
		check("pg drive level", 8'(pg_o), 8'h00);
		check("sda drive level", 8'(sda_o), 8'h00);
		check("sda idle", 8'(sda_oe), 8'h00);
		rd(CTRL_TWO_OFS, 8'hC1);
	endtask
	// every frequency and limit code, then refused writes leave the value alone
	task automatic t_fields();
		for (int i = 0; i < 8; i++) begin
			wr({2'h3, 2'(i), 1'b0, 3'(i)});
			check("freq", 8'(freq_sel), 8'(i % 4));
			check("limit", 8'(valley_limit_sel), 8'(i));
			rd(CTRL_TWO_OFS, {2'h3, 2'(i), 1'b0, 3'(i)});
		end
		i_cct_i2c_host.write_reg(ADDR, 8'h05, 8'hFF, ok);
		rd(8'h05, UNMAPPED_DATA);
		i_cct_i2c_host.write_reg(ADDR + 7'h01, CTRL_TWO_OFS, 8'h00, ok);
		check("foreign addr ack", 8'(ok), 8'h00);
		rd(CTRL_TWO_OFS, 8'hF7);
	endtask
	task automatic t_soft();
		wr(8'hC9);
		check("soft while enabled", 8'(soft_stop_active), 8'h00);
		converter_enable = 1'b0;
		repeat (6) @(negedge clk);
		check("soft after shutdown", 8'(soft_stop_active), 8'h01);
		wr(8'hC1);
		check("soft cleared", 8'(soft_stop_active), 8'h00);
		converter_enable = 1'b1;
	endtask
	// a blip shorter than the delay is ignored, then each code both ways
	task automatic t_pg();
		fb_in_window = 1'b1;
		repeat (PGD3_SMALL - 10) @(negedge clk);
		fb_in_window = 1'b0;
		repeat (60) @(negedge clk);
		check("pg after blip", 8'(power_good_flag), 8'h00);
		for (int c = 0; c < 4; c++) begin
			wr({2'(c), 6'h01});
			fb_in_window = 1'b1;
			wait_pg(1'b1, dly[c]);
			fb_in_window = 1'b0;
			wait_pg(1'b0, dly[c]);
		end
	endtask
	initial begin
		dly = '{PGD0_CYC, PGD1_CYC, PGD2_CYC, PGD3_SMALL};
		n_mismatch = 0;
		tests_run = 0;
		rst_n = 1'b0;
		fb_in_window = 1'b0;
		converter_enable = 1'b1;
		repeat (12) @(negedge clk);
		rst_n = 1'b1;
		repeat (4) @(negedge clk);
		t_reset();
		t_fields();
		t_soft();
		t_pg();
		wrap_up();
	end
endmodule
`default_nettype wire
